// ---- aic_pkg.sv ----
package aic_pkg;

    // ************************************************************
    // Data widths and sizes
    // ************************************************************
    localparam int RES_W      = 12;
    localparam int CH_W       = 2;
    localparam int NCH        = 4;
    localparam int FIFO_DEPTH = 16;
    localparam int CNT_W      = 4;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int  CLK_NS  = 4;
    localparam real ACQ_US  = 0.6;
    localparam int  ACQ_CYC = int'($floor(ACQ_US * 1000.0 / real'(CLK_NS)));
    localparam int  ACQ_W   = 8;

    // ************************************************************
    // Protocol fields and reset values
    // ************************************************************
    localparam logic [CNT_W-1:0] BYTE_BITS   = 4'h8;
    localparam logic [4:0]       HS_CODE_PFX = 5'h01;
    localparam int               CFG_CH_LSB  = 4;
    localparam logic [7:0]       CFG_RESET   = 8'hF0;
    localparam logic [6:0]       DEV_ADDR    = 7'h28;

    typedef struct packed {
        logic [CH_W-1:0]  ch;
        logic [RES_W-1:0] data;
    } aic_result_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } aic_link_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_AACK,
        ST_WR,
        ST_WACK,
        ST_RD,
        ST_RACK,
        ST_SKIP
    } aic_state_t;

endpackage : aic_pkg

// ---- aic_mem.sv ----
module aic_mem #(
    parameter int W = 14,
    parameter int D = 16
) (
    input  wire logic                 clk,
    input  wire logic                 rstn,
    input  wire logic                 we,
    input  wire logic [$clog2(D)-1:0] waddr,
    input  wire logic [W-1:0]         wdata,
    input  wire logic [$clog2(D)-1:0] raddr,
    output logic      [W-1:0]         rdata
);

    logic [W-1:0] mem [D];

    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rdata <= '0;
        end
        else
        begin
            rdata <= mem[raddr];
        end
    end

endmodule : aic_mem

// ---- aic_fifo.sv ----
module aic_fifo #(
    parameter int W     = 14,
    parameter int DEPTH = 16
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);

    localparam int PW = $clog2(DEPTH);

    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0]   count;
    logic          push;
    logic          pop;

    assign in_ready = (count != (PW+1)'(DEPTH));
    assign push     = in_valid && in_ready;
    assign pop      = out_valid && out_ready;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    // Valid lags the count by a cycle so it always matches the registered read data
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            out_valid <= 1'b0;
        end
        else
        begin
            out_valid <= (count != '0) && !pop;
        end
    end

    aic_mem #(
        .W (W),
        .D (DEPTH)
    ) u_mem (
        .clk   (clk),
        .rstn  (rstn),
        .we    (push),
        .waddr (wr_ptr),
        .wdata (in_data),
        .raddr (rd_ptr),
        .rdata (out_data)
    );

endmodule : aic_fifo

// ---- aic_read_ctrl.sv ----
// Summary of operation
// - Each result read out as two bytes
// - Unlimited results within one read transfer
// - Acknowledge own read address by pulling low
// - Byte one: zeros, channel id, four MSBs
// - Byte two: low bits, trailing zeros per variant
// - Ninth address edge starts power-up and acquisition
// - Sample and convert after 0.6 us acquisition
// - Master ACK on second byte: convert again
// - Master NACK on second byte: no conversion
// - Follow-on conversion uses next sequence channel
// - Stop gives full shutdown, else partial
// - High speed master code is never acknowledged
// - Repeated start then address is acknowledged
// - High speed held until stop, then fast
// - Shutdown after reset until own read address acknowledged
// - All channels enabled by default
// - Config bits 7..4 enable channels, ascending
// - Config written as one byte after write address
module aic_read_ctrl #(
    parameter int RES_BITS = 12
) (
    input  wire logic                         clk,
    input  wire logic                         rstn,
    input  wire logic                         scl_in,
    input  wire logic                         sda_in,
    output logic                              sda_out,
    output logic                              sda_oe_n,
    output logic                              full_sd,
    output logic                              pwr_up,
    output logic                              hs_mode,
    output logic                              conv_start,
    output logic [aic_pkg::CH_W-1:0]          conv_chan,
    input  wire logic                         res_valid,
    input  wire logic [aic_pkg::RES_W-1:0]    res_data,
    output logic                              res_ready,
    output logic [7:0]                        cfg
);

    // ************************************************************
    // Pin synchronisers and bus conditions
    // ************************************************************
    aic_pkg::aic_link_t sync1;
    aic_pkg::aic_link_t sync2;
    aic_pkg::aic_link_t last;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sync1 <= '{scl: 1'b1, sda: 1'b1};
            sync2 <= '{scl: 1'b1, sda: 1'b1};
            last  <= '{scl: 1'b1, sda: 1'b1};
        end
        else
        begin
            sync1 <= '{scl: scl_in, sda: sda_in};
            sync2 <= sync1;
            last  <= sync2;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    assign scl_rise  = sync2.scl && !last.scl;
    assign scl_fall  = !sync2.scl && last.scl;
    assign bus_start = sync2.scl && last.scl && last.sda && !sync2.sda;
    assign bus_stop  = sync2.scl && last.scl && !last.sda && sync2.sda;

    // ************************************************************
    // Channel sequence and output byte decode
    // ************************************************************
    // Scans upward from the current channel, wrapping; a lone channel repeats
    function automatic logic [1:0] next_en(input logic [3:0] en, input logic [1:0] cur);
        logic [1:0] idx;
        idx     = cur;
        next_en = cur;
        for (int i = 4; i >= 1; i--)
        begin
            idx = cur + 2'(i);
            if (en[idx])
            begin
                next_en = idx;
            end
        end
    endfunction : next_en

    aic_pkg::aic_result_t cur;
    logic                 byte_sel;
    logic [7:0]           out_byte;
    logic [7:0]           low_mask;

    assign low_mask = 8'hFF << (aic_pkg::RES_W - RES_BITS);
    assign out_byte = byte_sel ? (cur.data[7:0] & low_mask)
                               : {2'h0, cur.ch, cur.data[aic_pkg::RES_W-1:8]};

    // ************************************************************
    // Serial state machine
    // ************************************************************
    aic_pkg::aic_state_t             state;
    logic [aic_pkg::CNT_W-1:0]       cnt;
    logic [7:0]                      sh;
    logic                            rw;
    logic                            acked;
    logic                            addr_hit;
    logic                            ack_cont;
    logic                            nack_end;
    logic                            acq_start;

    assign addr_hit  = (state == aic_pkg::ST_AACK) && scl_rise && rw;
    assign ack_cont  = (state == aic_pkg::ST_RACK) && scl_rise && !sync2.sda && byte_sel;
    assign nack_end  = (state == aic_pkg::ST_RACK) && scl_rise && sync2.sda && byte_sel;
    assign acq_start = addr_hit || ack_cont;
    assign sda_out   = 1'b0;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state    <= aic_pkg::ST_IDLE;
            cnt      <= '0;
            sh       <= '0;
            rw       <= 1'b0;
            acked    <= 1'b0;
            byte_sel <= 1'b0;
            sda_oe_n <= 1'b1;
            cfg      <= aic_pkg::CFG_RESET;
        end
        else if (bus_stop)
        begin
            state    <= aic_pkg::ST_IDLE;
            sda_oe_n <= 1'b1;
        end
        else if (bus_start)
        begin
            state    <= aic_pkg::ST_ADDR;
            cnt      <= '0;
            sda_oe_n <= 1'b1;
        end
        else
        begin
            unique case (state)
                aic_pkg::ST_IDLE, aic_pkg::ST_SKIP:
                begin
                end
                aic_pkg::ST_ADDR, aic_pkg::ST_WR:
                begin
                    if (scl_rise)
                    begin
                        sh  <= {sh[6:0], sync2.sda};
                        cnt <= cnt + 1'b1;
                    end
                    else if (scl_fall && cnt == aic_pkg::BYTE_BITS)
                    begin
                        if (state == aic_pkg::ST_WR)
                        begin
                            cfg      <= sh;
                            state    <= aic_pkg::ST_WACK;
                            sda_oe_n <= 1'b0;
                        end
                        else if (sh[7:1] == aic_pkg::DEV_ADDR)
                        begin
                            rw       <= sh[0];
                            state    <= aic_pkg::ST_AACK;
                            sda_oe_n <= 1'b0;
                        end
                        else
                        begin
                            state <= aic_pkg::ST_SKIP;
                        end
                    end
                end
                aic_pkg::ST_AACK:
                begin
                    if (scl_fall)
                    begin
                        cnt      <= '0;
                        byte_sel <= 1'b0;
                        state    <= rw ? aic_pkg::ST_RD : aic_pkg::ST_WR;
                        sda_oe_n <= !rw;
                    end
                end
                aic_pkg::ST_WACK:
                begin
                    // Only one configuration byte is taken per transfer
                    if (scl_fall)
                    begin
                        sda_oe_n <= 1'b1;
                        state    <= aic_pkg::ST_SKIP;
                    end
                end
                aic_pkg::ST_RD:
                begin
                    if (scl_rise)
                    begin
                        cnt <= cnt + 1'b1;
                    end
                    else if (scl_fall)
                    begin
                        if (cnt == aic_pkg::BYTE_BITS)
                        begin
                            state    <= aic_pkg::ST_RACK;
                            sda_oe_n <= 1'b1;
                        end
                        else
                        begin
                            sda_oe_n <= out_byte[3'(4'h7 - cnt)];
                        end
                    end
                end
                aic_pkg::ST_RACK:
                begin
                    if (scl_rise)
                    begin
                        acked <= !sync2.sda;
                    end
                    else if (scl_fall)
                    begin
                        if (acked)
                        begin
                            // First bit of the first byte is a zero bit; of the second byte it is data bit 7 under low_mask
                            state    <= aic_pkg::ST_RD;
                            cnt      <= '0;
                            byte_sel <= !byte_sel;
                            sda_oe_n <= byte_sel ? 1'b0 : (cur.data[7] & low_mask[7]);
                        end
                        else
                        begin
                            state <= aic_pkg::ST_SKIP;
                        end
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // Power and speed mode
    // ************************************************************
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            full_sd <= 1'b1;
        end
        else if (bus_stop)
        begin
            full_sd <= 1'b1;
        end
        else if (addr_hit)
        begin
            full_sd <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            hs_mode <= 1'b0;
        end
        else if (bus_stop)
        begin
            hs_mode <= 1'b0;
        end
        else if (state == aic_pkg::ST_ADDR && scl_fall && cnt == aic_pkg::BYTE_BITS
                 && sh[7:3] == aic_pkg::HS_CODE_PFX)
        begin
            hs_mode <= 1'b1;
        end
    end

    // ************************************************************
    // Acquisition, conversion and result path
    // ************************************************************
    logic [aic_pkg::ACQ_W-1:0] acq_cnt;
    logic [1:0]                ptr;
    logic [1:0]                acq_chan;
    logic [3:0]                ch_en;
    logic                      pending;
    logic                      fifo_valid;
    aic_pkg::aic_result_t      fifo_data;
    logic                      pop;

    assign ch_en    = cfg[aic_pkg::CFG_CH_LSB +: aic_pkg::NCH];
    assign acq_chan = addr_hit ? next_en(ch_en, 2'h3) : ptr;
    assign pop      = pending && fifo_valid;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            acq_cnt    <= '0;
            conv_start <= 1'b0;
            conv_chan  <= '0;
            ptr        <= '0;
            pwr_up     <= 1'b0;
        end
        else
        begin
            conv_start <= (acq_cnt == 8'h01);
            if (acq_start)
            begin
                acq_cnt   <= aic_pkg::ACQ_W'(aic_pkg::ACQ_CYC);
                pwr_up    <= 1'b1;
                conv_chan <= acq_chan;
                ptr       <= next_en(ch_en, acq_chan);
            end
            else
            begin
                if (acq_cnt != '0)
                begin
                    acq_cnt <= acq_cnt - 1'b1;
                end
                if (res_valid && res_ready)
                begin
                    pwr_up <= 1'b0;
                end
            end
        end
    end

    // A result may land mid-byte; bits not yet shifted show the new value
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pending <= 1'b0;
            cur     <= '0;
        end
        else
        begin
            if (acq_start)
            begin
                pending <= 1'b1;
            end
            else if (pop)
            begin
                pending <= 1'b0;
            end
            if (pop)
            begin
                cur <= fifo_data;
            end
        end
    end

    aic_fifo #(
        .W     ($bits(aic_pkg::aic_result_t)),
        .DEPTH (aic_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rstn      (rstn),
        .in_valid  (res_valid),
        .in_ready  (res_ready),
        .in_data   ({conv_chan, res_data}),
        .out_valid (fifo_valid),
        .out_ready (pending),
        .out_data  (fifo_data)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    localparam int ACQ_D   = aic_pkg::ACQ_CYC;
    // The sample pulse is registered off the last count, so it is seen one cycle later
    localparam int ACQ_END = aic_pkg::ACQ_CYC + 1;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_ack_pull_low: assert property (state == aic_pkg::ST_AACK |-> !sda_oe_n)
        else $error("address ack not driven low");
    a_acq_to_sample: assert property (acq_start |-> ##[ACQ_END:ACQ_END] conv_start)
        else $error("sample not taken after acquisition time");
    a_ack_reconvert: assert property (ack_cont |=> pwr_up && acq_cnt == 8'(ACQ_D))
        else $error("ack did not start another conversion");
    a_nack_stops: assert property (nack_end |=> !acked && !$rose(pwr_up))
        else $error("nack did not end conversions");
    a_stop_shutdown: assert property (bus_stop |=> full_sd && !hs_mode)
        else $error("stop did not give full shutdown");
    a_wake_on_addr: assert property ($fell(full_sd) |-> $past(addr_hit))
        else $error("left shutdown without own address");
    a_chan_enabled: assert property (conv_start && ch_en != 4'h0 |-> ch_en[conv_chan])
        else $error("converted a disabled channel");
    a_first_byte: assert property (state == aic_pkg::ST_RD && !byte_sel && scl_fall
        && cnt == 4'h1 |=> !sda_oe_n)
        else $error("first byte header wrong");
    a_hs_no_ack: assert property ($rose(hs_mode) |-> sda_oe_n && state == aic_pkg::ST_SKIP)
        else $error("high speed code acknowledged");

    c_read_more: cover property (ack_cont);
    c_read_end: cover property (nack_end);
    c_hs_entry: cover property ($rose(hs_mode));
    c_cfg_write: cover property (state == aic_pkg::ST_WACK);

endmodule : aic_read_ctrl

// ---- aic_master.sv ----
module aic_master (
    input  wire logic clk,
    input  wire logic sda_oe_n,
    input  wire logic sda_out,
    output logic      scl,
    output wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;

    // ********************************
    // Bus master with pull-up on SDA
    // ********************************
    logic    sda_m = 1'b1;
    realtime t_ninth = 0.0;

    // Released line floats high through the pull-up
    assign sda = sda_m & (sda_oe_n | sda_out);

    initial scl = 1'b1;

    task automatic q(input int n);
        repeat (n) @(negedge clk);
    endtask : q

    // SDA only moves while SCL is low, so no false start or stop
    task automatic bit_x(input logic b, input int hold, output logic got);
        sda_m = b;
        q(4);
        scl = 1'b1;
        t_ninth = $realtime;
        q(4);
        got = sda;
        q(4 + hold);
        scl = 1'b0;
        q(4);
    endtask : bit_x

    task automatic start();
        sda_m = 1'b1;
        q(4);
        scl = 1'b1;
        q(4);
        sda_m = 1'b0;
        q(4);
        scl = 1'b0;
        q(4);
    endtask : start

    task automatic stop();
        sda_m = 1'b0;
        q(4);
        scl = 1'b1;
        q(4);
        sda_m = 1'b1;
        q(8);
    endtask : stop

    task automatic wbyte(input logic [7:0] d, input int hold, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) bit_x(d[i], 0, g);
        bit_x(1'b1, hold, g);
        ack = ~g;
    endtask : wbyte

    task automatic rbyte(input logic ack, input int hold, output logic [7:0] d);
        logic g;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, 0, d[i]);
        bit_x(~ack, hold, g);
    endtask : rbyte
endmodule : aic_master

// ---- aic_read_ctrl_test.sv ----
module aic_read_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;

    // ********************************
    // Bench signals and table
    // ********************************
    typedef struct packed {
        logic [7:0] cfg;
        logic [5:0] chs;
    } aic_row_t;

    localparam int       STR = 500;
    localparam aic_row_t ROWS [5] = '{'{8'hF0, 6'h06}, '{8'h10, 6'h00}, '{8'hA0, 6'h1D},
                                      '{8'hC0, 6'h2E}, '{8'h90, 6'h0C}};

    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        scl, sda_out, sda_oe_n, full_sd, pwr_up, hs_mode, conv_start, res_ready;
    wire logic   sda;
    logic [1:0]  conv_chan, ch_cap;
    logic        res_valid = 1'b0;
    logic [11:0] res_data = 12'h000;
    logic [7:0]  cfg;
    logic        pw_cap, sd_cap;
    logic        f_iv = 1'b0;
    logic [11:0] f_id = 12'h000;
    int          err_total = 0;
    int          checked = 0;
    int          n_conv = 0;
    realtime     t_conv = 0.0;

    always #2 clk = ~clk;

    aic_read_ctrl i_dut (.clk, .rstn, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe_n,
        .full_sd, .pwr_up, .hs_mode, .conv_start, .conv_chan,
        .res_valid(res_valid | f_iv), .res_data(f_iv ? f_id : res_data),
        .res_ready, .cfg);
    aic_master i_mst (.clk, .sda_oe_n, .sda_out, .scl, .sda);

    function automatic logic [11:0] rdat(input logic [1:0] ch);
        return 12'hA5C ^ {ch, ch, ch, ch, ch, ch};
    endfunction : rdat

    // Converter: one result per start, held until taken
    initial
    begin
        forever
        begin
            @(posedge clk iff conv_start === 1'b1);
            n_conv++;
            t_conv = $realtime;
            ch_cap = conv_chan;
            pw_cap = pwr_up;
            sd_cap = full_sd;
            repeat (40) @(negedge clk);
            res_data = rdat(ch_cap);
            res_valid = 1'b1;
            @(posedge clk iff res_ready === 1'b1);
            @(negedge clk);
            res_valid = 1'b0;
        end
    end

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic give_verdict();
        if (err_total == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    task automatic read_run(input logic [5:0] chs, input int n);
        logic [7:0]  b1, b2;
        logic [11:0] d;
        logic [1:0]  ch;
        logic        ack;
        realtime     dt;
        int          base;
        base = n_conv;
        i_mst.wbyte({aic_pkg::DEV_ADDR, 1'b1}, STR, ack);
        chk("read ack", 1, ack);
        for (int k = 0; k < n; k++)
        begin
            ch = chs[5 - 2 * k -: 2];
            d = rdat(ch);
            dt = t_conv - i_mst.t_ninth;
            chk("convs", base + k + 1, n_conv);
            chk("acq", 1, dt >= 600.0 && dt <= 630.0);
            chk("power", 2'b10, {pw_cap, sd_cap});
            i_mst.rbyte(1'b1, 0, b1);
            chk("byte1", {2'b00, ch, d[11:8]}, b1);
            i_mst.rbyte(k < n - 1, (k < n - 1) ? STR : 0, b2);
            chk("byte2", d[7:0], b2);
        end
        i_mst.q(700);
        chk("no conv", base + n, n_conv);
        chk("partial", 0, full_sd);
    endtask : read_run

    initial
    begin
        repeat (60000) @(posedge clk);
        err_total++;
        give_verdict();
    end

    // ********************************
    // Main sequence
    // ********************************
    initial
    begin
        logic       ack;
        int         nb;
        logic [7:0] b1, b2;
        repeat (6) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        for (int r = 0; r < 5; r++)
        begin
            i_mst.start();
            i_mst.wbyte({aic_pkg::DEV_ADDR, 1'b0}, 0, ack);
            chk("write ack", 1, ack);
            i_mst.wbyte(ROWS[r].cfg, 0, ack);
            i_mst.stop();
            chk("cfg", ROWS[r].cfg, cfg);
            i_mst.start();
            read_run(ROWS[r].chs, 3);
            i_mst.stop();
            chk("full sd", 1, full_sd);
        end
        rstn = 1'b0;
        repeat (6) @(negedge clk);
        chk("reset", 16'h31F0, {sda_oe_n, full_sd, pwr_up, hs_mode, conv_start, res_ready, cfg});
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        // Foreign address must leave the part asleep
        nb = n_conv;
        i_mst.start();
        i_mst.wbyte({aic_pkg::DEV_ADDR ^ 7'h01, 1'b1}, STR, ack);
        chk("wrong ack", 0, ack);
        chk("wrong conv", nb, n_conv);
        chk("asleep", 1, full_sd);
        i_mst.stop();
        i_mst.start();
        i_mst.wbyte(8'h09, 0, ack);
        chk("hs ack", 0, ack);
        chk("hs on", 1, hs_mode);
        i_mst.start();
        read_run(6'h00, 1);
        chk("hs held", 1, hs_mode);
        i_mst.stop();
        chk("hs off", 2'b01, {hs_mode, full_sd});
        // Only one data byte fits the configuration
        i_mst.start();
        i_mst.wbyte({aic_pkg::DEV_ADDR, 1'b0}, 0, ack);
        i_mst.wbyte(8'h20, 0, ack);
        chk("cfg ack", 1, ack);
        i_mst.wbyte(8'h40, 0, ack);
        chk("extra ack", 0, ack);
        i_mst.stop();
        chk("cfg kept", 8'h20, cfg);
        // Buffer: with no read pending, results queue until the seventeenth is refused
        f_iv = 1'b1;
        for (int i = 0; i < 17; i++)
        begin
            f_id = 12'(i);
            chk("fifo ready", i < 16, res_ready);
            @(negedge clk);
        end
        f_iv = 1'b0;
        // Queued results come out oldest first; each read refills one slot
        i_mst.start();
        i_mst.wbyte({aic_pkg::DEV_ADDR, 1'b1}, 0, ack);
        for (int i = 0; i < 16; i++)
        begin
            i_mst.rbyte(1'b1, 0, b1);
            i_mst.rbyte(i < 15, 0, b2);
            chk("fifo data", 16'(i), {b1, b2});
        end
        i_mst.stop();
        chk("fifo refilled", 0, res_ready);
        give_verdict();
    end
endmodule : aic_read_ctrl_test
